// [core/acpi_apm_power_event_logic.sv]
// acpi pm1 event, enable, control and apm ports with sleep sequencing
`timescale 1ns/1ps
`include "pm_event_consts.svh"

module acpi_apm_power_event_logic #(
  parameter int unsigned OVERRIDE_CYCLES = `OVERRIDE_CYCLES
) (
  // clock and resets
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_hard_reset,
  // i/o cycles from pci
  input wire pm_event_pkg::io_req_t i_io,
  input wire logic [15:0] i_acpi_base,
  output logic [15:0] o_rdata,
  output logic o_hit,
  // apm smi control bits
  input wire logic i_apm_port_smi_enable,
  input wire logic i_legacy_timer_smi_enable,
  input wire logic i_global_smi_enable,
  // platform signals
  input wire logic i_power_button,
  input wire logic i_alarm_interrupt_line_n,
  input wire logic i_resume_well_reset_n,
  input wire logic i_main_power_good,
  input wire logic i_wake_other,
  // outputs
  output logic o_sci,
  output logic o_smi,
  output logic o_apm_smi_pulse,
  output logic o_stay_off_after_power_loss,
  output pm_event_pkg::power_state_t o_state,
  output pm_event_pkg::sleep_pins_t o_pins
);

  localparam int unsigned TICK_NUM = `TIMER_HZ;
  localparam int unsigned TICK_DEN = `CLK_HZ;
  localparam logic [15:0] STS_MASK = `STATUS_MASK;
  localparam logic [15:0] KEEP_MASK = `STATUS_KEEP_MASK;

  logic [15:0] status_q;
  wire [15:0] status_d;
  logic [15:0] enable_q;
  logic [15:0] enable_d;
  logic [2:0] sleep_type_q;
  logic sci_route_q;
  logic [7:0] apm_cmd_q;
  logic [7:0] apm_scr_q;
  logic [23:0] tmr_q;
  logic [25:0] frac_q;
  logic [31:0] hold_q;
  logic button_q;
  logic alarm_q;
  logic rsm_lost_q;
  logic stay_off_q;
  logic apm_smi_q;
  pm_event_pkg::power_state_t state_q;
  pm_event_pkg::power_state_t state_d;

  // address decode
  wire [15:0] rel = i_io.addr - i_acpi_base;
  wire in_acpi = (i_io.addr >= i_acpi_base) && (rel < 16'h0006);
  wire sel_sts = in_acpi && (rel[7:0] == `OFS_EVENT_STATUS);
  wire sel_en = in_acpi && (rel[7:0] == `OFS_EVENT_ENABLE);
  wire sel_ctl = in_acpi && (rel[7:0] == `OFS_SLEEP_CONTROL);
  wire sel_apm_command_port = (i_io.addr == {8'h00, `OFS_APM_COMMAND});
  wire sel_apm_scratch_status = (i_io.addr == {8'h00, `OFS_APM_SCRATCH});
  wire wr_full = i_io.wr && (i_io.be == 2'h3);
  wire wr_apm_command_port = i_io.wr && sel_apm_command_port;
  wire wr_apm_scratch_status = i_io.wr && sel_apm_scratch_status;
  wire [15:0] wmask = {{8{i_io.be[1]}}, {8{i_io.be[0]}}};

  // timer tick, fractional divider from the system clock
  wire [25:0] frac_sum = frac_q + 26'(TICK_NUM);
  wire tick = frac_sum >= 26'(TICK_DEN);
  wire [23:0] tmr_next = tick ? tmr_q + 24'h000001 : tmr_q;
  wire tmr_fall = tmr_q[`TIMER_BIT_WATCH] && !tmr_next[`TIMER_BIT_WATCH];

  // event sources
  wire press = i_power_button && !button_q;
  wire override_hit = i_power_button &&
    (hold_q == 32'(OVERRIDE_CYCLES - 1));
  wire alarm_edge = !i_alarm_interrupt_line_n && alarm_q;
  wire fw_release = i_io.wr && sel_ctl && i_io.wdata[`BIT_FW_RELEASE] &&
    i_io.be[0];
  wire asleep = (state_q != pm_event_pkg::ST_ON);
  wire alarm_wake = status_q[`BIT_ALARM] && enable_q[`BIT_ALARM] &&
    !rsm_lost_q;
  wire wake_ev = asleep && (alarm_wake || press || i_wake_other);
  wire sleep_go = i_io.wr && sel_ctl && i_io.be[1] &&
    i_io.wdata[`BIT_SLEEP_TRIGGER];
  wire [2:0] new_type = i_io.be[1] ?
    i_io.wdata[`SLEEP_TYPE_HI:`SLEEP_TYPE_LO] : sleep_type_q;

  // set events, write-one-clear; set beats clear
  wire [15:0] set_vec = {wake_ev, 3'h0, override_hit, alarm_edge, 1'b0,
    press, 2'h0, fw_release, 4'h0, tmr_fall};
  wire [15:0] clr_vec = (i_io.wr && sel_sts) ? (i_io.wdata & wmask) : 16'h0;

  // per-bit status flags; hard reset clears only the flags not kept
  generate
    for (genvar b = 0; b < 16; b++)
    begin : g_status
      wire live = STS_MASK[b];
      wire kept = KEEP_MASK[b];
      wire held = status_q[b] && !clr_vec[b];
      wire flag_nxt = (held || set_vec[b]) && live;
      assign status_d[b] = (i_hard_reset && !kept) ? 1'b0 : flag_nxt;
    end
  endgenerate

  always_comb
  begin
    enable_d = enable_q;
    if (i_io.wr && sel_en)
      enable_d = ((enable_q & ~wmask) | (i_io.wdata & wmask)) & `ENABLE_MASK;
    if (override_hit)
      enable_d[`BIT_ALARM] = 1'b0;
  end

  // sleep sequencer
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      pm_event_pkg::ST_ON:
        if (sleep_go)
        begin
          case (new_type)
            3'h1: state_d = pm_event_pkg::ST_S1_STOP;
            3'h2: state_d = pm_event_pkg::ST_S1_SLEEP;
            3'h3: state_d = pm_event_pkg::ST_S3;
            3'h4: state_d = pm_event_pkg::ST_S5;
            default: state_d = pm_event_pkg::ST_ON;
          endcase
        end
      pm_event_pkg::ST_S1_STOP,
      pm_event_pkg::ST_S1_SLEEP,
      pm_event_pkg::ST_S3,
      pm_event_pkg::ST_S5:
        if (wake_ev)
          state_d = pm_event_pkg::ST_ON;
      default: state_d = pm_event_pkg::ST_ON;
    endcase
    if (override_hit)
      state_d = pm_event_pkg::ST_S5;
  end

  // flags that survive the hard reset, except the status flags outside the keep mask
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      status_q <= 16'h0000;
      enable_q <= 16'h0000;
      stay_off_q <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      enable_q <= enable_d;
      if (override_hit)
        stay_off_q <= 1'b1;
    end
  end

  // control register fields
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      sleep_type_q <= 3'h0;
    else if (i_io.wr && sel_ctl)
      sleep_type_q <= new_type;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      sci_route_q <= 1'b0;
    else if (i_io.wr && sel_ctl && i_io.be[0])
      sci_route_q <= i_io.wdata[`BIT_SCI_ROUTE];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      state_q <= pm_event_pkg::ST_ON;
    else
      state_q <= state_d;
  end

  // apm ports and their smi pulse
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      apm_cmd_q <= 8'h00;
    else if (wr_apm_command_port)
      apm_cmd_q <= i_io.wdata[7:0];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      apm_scr_q <= 8'h00;
    else if (wr_apm_scratch_status)
      apm_scr_q <= i_io.wdata[7:0];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      apm_smi_q <= 1'b0;
    else
      apm_smi_q <= wr_apm_command_port && i_apm_port_smi_enable;
  end

  // timer and its fractional divider
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      tmr_q <= 24'h000000;
    else
      tmr_q <= tmr_next;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      frac_q <= 26'h0;
    else
      frac_q <= tick ? frac_sum - 26'(TICK_DEN) : frac_sum;
  end

  // button hold counter and edge detectors
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !i_power_button || override_hit)
      hold_q <= 32'h0;
    else
      hold_q <= hold_q + 32'h1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      button_q <= 1'b0;
    else
      button_q <= i_power_button;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      alarm_q <= 1'b1;
    else
      alarm_q <= i_alarm_interrupt_line_n;
  end

  // resume well loss blocks alarm resume until back on
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      rsm_lost_q <= 1'b0;
    else if (!i_resume_well_reset_n)
      rsm_lost_q <= 1'b1;
    else if (!asleep)
      rsm_lost_q <= 1'b0;
  end

  // interrupt requests
  wire tmr_active = status_q[`BIT_TIMER] && enable_q[`BIT_TIMER];
  wire sci_tmr = tmr_active && sci_route_q;
  wire smi_tmr = tmr_active && !sci_route_q && i_legacy_timer_smi_enable &&
    i_global_smi_enable;
  wire btn_active = status_q[`BIT_BUTTON] && enable_q[`BIT_BUTTON];
  wire fw_active = status_q[`BIT_FIRMWARE] && enable_q[`BIT_FIRMWARE];
  assign o_sci = sci_tmr || fw_active || (btn_active && sci_route_q);
  assign o_smi = smi_tmr || apm_smi_q ||
    (btn_active && !sci_route_q);
  assign o_apm_smi_pulse = apm_smi_q;

  // read data, reserved bits zero
  wire [15:0] ctl_rd = {2'h0, 1'b0, sleep_type_q, 9'h0, sci_route_q};
  assign o_hit = sel_sts || sel_en || sel_ctl || sel_apm_command_port || sel_apm_scratch_status;
  assign o_rdata = !i_io.rd ? 16'h0000 :
    sel_sts ? (status_q & `STATUS_MASK) :
    sel_en ? (enable_q & `ENABLE_MASK) :
    sel_ctl ? ctl_rd :
    sel_apm_command_port ? {8'h00, apm_cmd_q} :
    sel_apm_scratch_status ? {8'h00, apm_scr_q} : 16'h0000;

  // sleep pins per state
  assign o_state = state_q;
  assign o_stay_off_after_power_loss = stay_off_q;
  always_comb
  begin
    o_pins.cpu_stop_clock_n = 1'b1;
    o_pins.cpu_sleep_line_n = 1'b1;
    o_pins.suspend_output = 1'b0;
    o_pins.soft_off = 1'b0;
    case (state_q)
      pm_event_pkg::ST_S1_STOP:
        o_pins.cpu_stop_clock_n = 1'b0;
      pm_event_pkg::ST_S1_SLEEP:
      begin
        o_pins.cpu_stop_clock_n = 1'b0;
        o_pins.cpu_sleep_line_n = 1'b0;
      end
      pm_event_pkg::ST_S3:
        o_pins.suspend_output = 1'b1;
      pm_event_pkg::ST_S5:
        o_pins.soft_off = 1'b1;
      default:
        o_pins.soft_off = 1'b0;
    endcase
  end

  // main power good alone does not block alarm resume
  logic unused_ok;
  assign unused_ok = wr_full ^ i_main_power_good;

endmodule : acpi_apm_power_event_logic

// [core/pm_event_consts.svh]
// offsets, field positions, masks and timing counts for the pm event block
`ifndef PM_EVENT_CONSTS_SVH
`define PM_EVENT_CONSTS_SVH

`define OFS_EVENT_STATUS 8'h00
`define OFS_EVENT_ENABLE 8'h02
`define OFS_SLEEP_CONTROL 8'h04
`define OFS_APM_COMMAND 8'hb2
`define OFS_APM_SCRATCH 8'hb3

`define BIT_WAKE 15
`define BIT_OVERRIDE 11
`define BIT_ALARM 10
`define BIT_BUTTON 8
`define BIT_FIRMWARE 5
`define BIT_TIMER 0
`define BIT_SLEEP_TRIGGER 13
`define SLEEP_TYPE_LO 10
`define SLEEP_TYPE_HI 12
`define BIT_SCI_ROUTE 0
`define BIT_FW_RELEASE 2

`define STATUS_MASK 16'h8d21
`define ENABLE_MASK 16'h0521
`define CONTROL_MASK 16'h1c01
`define STATUS_KEEP_MASK 16'h8d00

`define CLK_HZ 50000000
`define TIMER_HZ 3579545
`define OVERRIDE_SECONDS 4
`define OVERRIDE_CYCLES (`OVERRIDE_SECONDS * `CLK_HZ)
`define TIMER_BIT_WATCH 22

`endif

// [core/pm_event_pkg.sv]
// types for the pm event block
package pm_event_pkg;

  typedef enum logic [4:0] {
    ST_ON = 5'h01,
    ST_S1_STOP = 5'h02,
    ST_S1_SLEEP = 5'h04,
    ST_S3 = 5'h08,
    ST_S5 = 5'h10
  } power_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } io_req_t;

  typedef struct packed {
    logic cpu_stop_clock_n;
    logic cpu_sleep_line_n;
    logic suspend_output;
    logic soft_off;
  } sleep_pins_t;

endpackage : pm_event_pkg

// [testbench/pm_event_props.sv]
// assertions on the pm event block ports
`timescale 1ns/1ps
module pm_event_props #(
  parameter int unsigned OVERRIDE_CYCLES = 50
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // inputs watched
  input wire pm_event_pkg::io_req_t i_io,
  input wire logic [15:0] i_acpi_base,
  input wire logic i_apm_port_smi_enable,
  input wire logic i_power_button,
  // outputs watched
  input wire logic [15:0] o_rdata,
  input wire logic o_hit,
  input wire logic o_apm_smi_pulse,
  input wire logic o_stay_off_after_power_loss,
  input wire pm_event_pkg::power_state_t o_state,
  input wire pm_event_pkg::sleep_pins_t o_pins
);
  logic [31:0] hold_q;
  wire cmd_en = i_io.wr && i_io.addr == 16'h00b2 && i_apm_port_smi_enable;
  wire ctl = i_io.addr == i_acpi_base + 16'h4;
  always_ff @(posedge i_clk)
    hold_q <= (i_sys_rst || !i_power_button) ? 32'h0 : hold_q + 32'h1;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  AST_APM_SMI: assert property (cmd_en |=> o_apm_smi_pulse)
    else $error("apm write gave no smi pulse");
  AST_APM_CAUSE: assert property (o_apm_smi_pulse |-> $past(cmd_en))
    else $error("smi pulse without enabled apm write");
  AST_UNMAPPED: assert property (i_io.rd && i_io.addr == 16'h0070
    |-> o_rdata == 16'h0 && !o_hit) else $error("unmapped read not zero");
  AST_STATUS_RSVD: assert property (i_io.rd && i_io.addr == i_acpi_base
    |-> (o_rdata & ~16'h8d21) == 16'h0) else $error("reserved status bits");
  AST_TRIGGER_RD: assert property (i_io.rd && ctl |-> !o_rdata[13])
    else $error("sleep trigger read as one");
  AST_PINS_S3: assert property (o_state == pm_event_pkg::ST_S3
    |-> o_pins.suspend_output) else $error("suspend output off in s3");
  AST_PINS_S1: assert property (o_state == pm_event_pkg::ST_S1_STOP
    |-> !o_pins.cpu_stop_clock_n && o_pins.cpu_sleep_line_n)
    else $error("s1 stop pins wrong");
  AST_WAKE: assert property ($rose(i_power_button)
    && o_state != pm_event_pkg::ST_ON |=> o_state == pm_event_pkg::ST_ON)
    else $error("button press did not wake");
  AST_OVERRIDE: assert property (hold_q == OVERRIDE_CYCLES + 2
    |-> o_state == pm_event_pkg::ST_S5 && o_stay_off_after_power_loss)
    else $error("button hold did not force s5");
  AST_RSVD_TYPE: assert property (i_io.wr && ctl
    && i_io.wdata[13:10] == 4'hf && o_state == pm_event_pkg::ST_ON
    |=> o_state == pm_event_pkg::ST_ON) else $error("reserved type left on");
endmodule : pm_event_props

// [testbench/pm_platform_model.sv]
// platform model: power button, alarm line and power rails
`timescale 1ns/1ps
module pm_platform_model (
  // clock
  input wire logic i_clk,
  // platform pins
  output logic o_power_button,
  output logic o_alarm_interrupt_line_n,
  output logic o_resume_well_reset_n,
  output logic o_main_power_good,
  output logic o_wake_other
);
  initial
  begin
    o_power_button = 1'b0;
    o_alarm_interrupt_line_n = 1'b1;
    o_resume_well_reset_n = 1'b1;
    o_main_power_good = 1'b1;
    o_wake_other = 1'b0;
  end
  // hold the button for n cycles
  task automatic press(input int n);
    @(negedge i_clk) o_power_button = 1'b1;
    repeat (n) @(negedge i_clk);
    o_power_button = 1'b0;
  endtask : press
  // one alarm pulse, active low
  task automatic alarm();
    @(negedge i_clk) o_alarm_interrupt_line_n = 1'b0;
    @(negedge i_clk) o_alarm_interrupt_line_n = 1'b1;
  endtask : alarm
endmodule : pm_platform_model

// [testbench/tb_top.sv]
// testbench for the pm event block
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned OVR = 50;
  localparam logic [15:0] B = 16'h0400;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic hrst = 1'b0;
  pm_event_pkg::io_req_t i_io = '0;
  logic global_smi_enable = 1'b0;
  logic apm_en = 1'b1;
  logic pb, al_n, rs_n, pg, wo, o_hit, sci, smi, pulse, stay;
  logic [15:0] o_rdata;
  pm_event_pkg::power_state_t st;
  pm_event_pkg::sleep_pins_t o_pins;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #10 i_clk = ~i_clk;
  acpi_apm_power_event_logic #(.OVERRIDE_CYCLES(OVR))
  u_acpi_apm_power_event_logic (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_hard_reset(hrst), .i_io(i_io), .i_acpi_base(B), .o_rdata(o_rdata),
    .o_hit(o_hit), .i_apm_port_smi_enable(apm_en),
    .i_legacy_timer_smi_enable(global_smi_enable), .i_global_smi_enable(global_smi_enable),
    .i_power_button(pb), .i_alarm_interrupt_line_n(al_n),
    .i_resume_well_reset_n(rs_n), .i_main_power_good(pg),
    .i_wake_other(wo), .o_sci(sci), .o_smi(smi), .o_apm_smi_pulse(pulse),
    .o_stay_off_after_power_loss(stay), .o_state(st), .o_pins(o_pins));
  pm_platform_model u_pm_platform_model (.i_clk(i_clk),
    .o_power_button(pb), .o_alarm_interrupt_line_n(al_n),
    .o_resume_well_reset_n(rs_n), .o_main_power_good(pg),
    .o_wake_other(wo));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, d, input logic [1:0] be);
    @(negedge i_clk);
    i_io = '{rd: 1'b0, wr: 1'b1, addr: a, be: be, wdata: d};
    @(negedge i_clk);
    i_io.wr = 1'b0;
  endtask : wr
  task automatic rdc(input logic [15:0] a, exp);
    @(negedge i_clk);
    i_io.addr = a;
    i_io.rd = 1'b1;
    #1 check(o_rdata, exp);
    check({15'h0, o_hit}, {15'h0, a != 16'h0070});
    @(negedge i_clk);
    i_io.rd = 1'b0;
  endtask : rdc
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      summarize();
    end
  end
  initial
  begin
    repeat (6) @(negedge i_clk);
    i_sys_rst = 1'b0;
    check(16'(st), 16'h1);
    wr(16'h00b2, 16'h005a, 2'b01);
    check({15'h0, pulse}, 16'h1);
    rdc(16'h00b2, 16'h005a);
    apm_en = 1'b0;
    wr(16'h00b2, 16'h0033, 2'b01);
    check({15'h0, pulse}, 16'h0);
    apm_en = 1'b1;
    wr(16'h00b3, 16'h00a5, 2'b01);
    rdc(16'h00b3, 16'h00a5);
    rdc(16'h0070, 16'h0);
    wr(B + 16'h2, 16'hffff, 2'b11);
    rdc(B + 16'h2, 16'h0521);
    for (int t = 1; t < 5; t++)
    begin
      wr(B + 16'h4, 16'h2001 | 16'(t) << 10, 2'b11);
      check(16'(st), 16'h1 << t);
      check(16'(o_pins), t == 1 ? 16'h4 : t == 2 ? 16'h0 :
        t == 3 ? 16'he : 16'hd);
      u_pm_platform_model.press(1);
      check(16'(st), 16'h1);
      rdc(B, 16'h8100);
      check({15'h0, sci}, 16'h1);
      wr(B, 16'h8100, 2'b11);
      check({15'h0, sci}, 16'h0);
    end
    rdc(B + 16'h4, 16'h1001);
    wr(B + 16'h4, 16'h3c01, 2'b11);
    check(16'(st), 16'h1);
    rdc(B + 16'h4, 16'h1c01);
    wr(B + 16'h4, 16'h0005, 2'b11);
    rdc(B, 16'h0020);
    check({15'h0, sci}, 16'h1);
    wr(B, 16'h0020, 2'b11);
    global_smi_enable = 1'b1;
    wr(B + 16'h4, 16'h0000, 2'b11);
    u_pm_platform_model.press(1);
    check({14'h0, smi, sci}, 16'h2);
    wr(B, 16'h0100, 2'b11);
    u_pm_platform_model.alarm();
    @(negedge i_clk) hrst = 1'b1;
    @(negedge i_clk) hrst = 1'b0;
    rdc(B, 16'h0400);
    wr(B, 16'h0400, 2'b11);
    u_pm_platform_model.press(OVR + 4);
    check(16'(st), 16'h10);
    check({15'h0, stay}, 16'h1);
    rdc(B + 16'h2, 16'h0121);
    summarize();
  end
endmodule : tb_top
bind acpi_apm_power_event_logic pm_event_props #(
  .OVERRIDE_CYCLES(OVERRIDE_CYCLES)) u_pm_event_props (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_io(i_io), .i_acpi_base(i_acpi_base),
  .i_apm_port_smi_enable(i_apm_port_smi_enable),
  .i_power_button(i_power_button), .o_rdata(o_rdata), .o_hit(o_hit),
  .o_apm_smi_pulse(o_apm_smi_pulse),
  .o_stay_off_after_power_loss(o_stay_off_after_power_loss),
  .o_state(o_state), .o_pins(o_pins));
